// File: shared/dhtm_consts.vh
// constants for the drive health and thermal monitor block
`ifndef DHTM_CONSTS_VH
`define DHTM_CONSTS_VH
// register byte offsets
`define DHTM_OFF_CTRL 8'h00
`define DHTM_OFF_REFT 8'h04
`define DHTM_OFF_STAT 8'h08
`define DHTM_OFF_SENSE 8'h0C
`define DHTM_OFF_TLEFT 8'h10
`define DHTM_OFF_TEMP 8'h14
// control register fields
`define DHTM_CTRL_DEX 0
`define DHTM_CTRL_ONLINE 1
`define DHTM_CTRL_EW 2
`define DHTM_CTRL_MR_LO 4
`define DHTM_CTRL_MR_HI 7
`define DHTM_CTRL_RST 8'h04
// status register fields
`define DHTM_ST_PF 0
`define DHTM_ST_TW 1
`define DHTM_ST_RND 2
`define DHTM_ST_BUSY 3
`define DHTM_ST_OFFL 4
`define DHTM_ST_PEND 5
// temperature limits in degrees c
`define DHTM_TRIP_MAX 8'h41
`define DHTM_REF_RST 8'h41
// sense key, asc and ascq codes
`define DHTM_KEY_REC 8'h01
`define DHTM_ASC_PF 8'h5D
`define DHTM_ASC_TW 8'h0B
`define DHTM_ASCQ_TW 8'h01
`define DHTM_ASC_RND 8'h37
`define DHTM_ASCQ_RND 8'h00
// timing
`define DHTM_CLK_HZ 25000000
`define DHTM_MEAS_SEC 7200
`define DHTM_TEMP_SEC 600
`define DHTM_ON_DLY_MS 118
`define DHTM_FULL_DLY_MS 146
`endif

// File: hw/dhtm_top.v
// drive health monitor with thermal trip points and axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dhtm_consts.vh"

// What this block does
// R1 - exception disable turns all monitoring off; here the temperature warning ignores it and is still raised
// R2 - performance bit skips all off-line measurement
// R3 - enabled monitor collects on-line data per operation
// R4 - rezero measures, saves, restarts two-hour timer
// R5 - time to next measurement readable by host
// R6 - save every two hours, deferred until idle
// R7 - started measurement and save runs to completion
// R8 - monitor delay within 118 or 146 ms
// R9 - predictive failure sense code via report method
// R10 - predictive failure code survives resets, power cycles
// R11 - interval and failure counters per attribute
// R12 - errors over threshold mark window unacceptable
// R13 - window end clears both counters
// R14 - history counter up bad, down good, floor zero
// R15 - history at predictive threshold signals failure
// R16 - temperature sampled at power-up, every ten minutes
// R17 - temperature over trip point raises warning code
// R18 - current temperature returned in unit code field
// R19 - warning gated by enable, delivered by method
// R20 - first trip point fixed at 65 c
// R21 - second trip point programmable, default 65 c
// R22 - reference above 65 clamps and reports rounding
// R23 - per-attribute limits constant, counters saturate
module dhtm_top #(
   parameter AW = 2,
   parameter [15:0] INTERVAL = 16'h03E8,
   parameter [15:0] ERR_THR = 16'h000A,
   parameter [7:0] PRED_THR = 8'h08,
   parameter SEC_CYC = `DHTM_CLK_HZ,
   parameter [15:0] MEAS_SEC = `DHTM_MEAS_SEC,
   parameter [15:0] TEMP_SEC = `DHTM_TEMP_SEC,
   parameter ON_DLY = `DHTM_ON_DLY_MS * (`DHTM_CLK_HZ / 1000),
   parameter FULL_DLY = `DHTM_FULL_DLY_MS * (`DHTM_CLK_HZ / 1000)
) (
   // clock, reset, enable
   input wire clk,
   input wire reset,
   input wire ce,
   // axi4-lite write channels
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read channels
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // drive activity
   input wire op_valid,
   input wire [AW-1:0] op_attr,
   input wire op_error,
   input wire host_idle,
   input wire rezero,
   input wire bus_reset_in,
   input wire [7:0] temp_in,
   // non-volatile failure record
   input wire nv_pf_in,
   output reg nv_pf_write,
   // report toward host
   output wire sense_valid,
   output reg [31:0] sense_code,
   output reg mon_busy,
   output reg offline_meas
);
   localparam NATTR = 1 << AW;

   // saturating increment shared by the interval and failure counters
   function [15:0] sat16;
      input [15:0] v;
      begin
         sat16 = (v == 16'hFFFF) ? v : v + 16'h0001;
      end
   endfunction

   reg [7:0] ctrl_q;
   reg [7:0] reft_q;
   reg [7:0] temp_q;
   reg pf_q;
   reg tw_q;
   reg rnd_q;
   reg pend_q;
   reg [AW-1:0] pf_attr_q;
   reg [31:0] pre_q;
   reg [15:0] meas_sec_q;
   reg [15:0] temp_sec_q;
   reg [31:0] busy_cnt_q;
   reg first_q;
   reg [15:0] ic_q [0:NATTR-1];
   reg [15:0] fc_q [0:NATTR-1];
   reg [7:0] hist_q [0:NATTR-1];
   reg [15:0] ic_n;
   reg [15:0] fc_n;
   reg [7:0] hist_n;
   reg pf_set;
   reg [AW-1:0] pf_at;
   integer i;

   wire dex = ctrl_q[`DHTM_CTRL_DEX];
   wire performance_priority_bit = ctrl_q[`DHTM_CTRL_ONLINE];
   wire ew = ctrl_q[`DHTM_CTRL_EW];
   wire [3:0] report_method_field = ctrl_q[`DHTM_CTRL_MR_HI:`DHTM_CTRL_MR_LO];
   wire sec_tick = (pre_q == SEC_CYC - 1);

   // both write channels are taken together, one response at a time
   wire wr_go = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire rd_go = ce & s_axi_arvalid & ~s_axi_rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   wire wr_ctrl = wr_go & (s_axi_awaddr == `DHTM_OFF_CTRL) & s_axi_wstrb[0];
   wire wr_reft = wr_go & (s_axi_awaddr == `DHTM_OFF_REFT) & s_axi_wstrb[0];
   wire wr_stat = wr_go & (s_axi_awaddr == `DHTM_OFF_STAT) & s_axi_wstrb[0];
   wire wr_ok = (s_axi_awaddr == `DHTM_OFF_CTRL) | (s_axi_awaddr == `DHTM_OFF_REFT)
      | (s_axi_awaddr == `DHTM_OFF_STAT);
   wire ref_over = (s_axi_wdata[31:0] > {24'h000000, `DHTM_TRIP_MAX});

   // temperature trips, first fixed, second user set
   wire trip = (temp_in > `DHTM_TRIP_MAX) | (temp_in > reft_q); // [R17] [R20] [R21]
   wire temp_sample = first_q | (sec_tick & (temp_sec_q == 16'h0000));
   wire tw_set = temp_sample & ew & trip; // [R19]

   // sense is offered only when a reporting method is chosen
   assign sense_valid = (pf_q | tw_q | rnd_q) & (report_method_field != 4'h0); // [R9] [R19]

   // one second prescaler, the time base of every long schedule
   always @(posedge clk or posedge reset)
   begin
      if (reset)
         pre_q <= 32'h00000000;
      else if (ce)
         pre_q <= sec_tick ? 32'h00000000 : pre_q + 32'h00000001;
   end

   // control and reference temperature registers
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ctrl_q <= `DHTM_CTRL_RST;
         reft_q <= `DHTM_REF_RST; // [R21]
      end
      else if (ce)
      begin
         if (wr_ctrl)
            ctrl_q <= s_axi_wdata[7:0];
         if (wr_reft)
            reft_q <= ref_over ? `DHTM_TRIP_MAX : s_axi_wdata[7:0]; // [R22]
      end
   end

   // write response; unmapped offsets answer slverr
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end
      else if (ce)
      begin
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // read data path
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end
      else if (ce)
      begin
         if (rd_go)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
               `DHTM_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl_q};
               `DHTM_OFF_REFT: s_axi_rdata <= {24'h000000, reft_q};
               `DHTM_OFF_STAT: s_axi_rdata <= {{(24-AW){1'b0}}, pf_attr_q,
                  2'b00, pend_q, offline_meas, mon_busy, rnd_q, tw_q, pf_q};
               `DHTM_OFF_SENSE: s_axi_rdata <= sense_code;
               `DHTM_OFF_TLEFT: s_axi_rdata <= {16'h0000, meas_sec_q}; // [R5]
               `DHTM_OFF_TEMP: s_axi_rdata <= {24'h000000, temp_q};
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // temperature sampling: once after reset, then every ten minutes
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         first_q <= 1'b1;
         temp_q <= 8'h00;
         temp_sec_q <= 16'h0000;
      end
      else if (ce)
      begin
         first_q <= 1'b0;
         if (temp_sample)
            temp_q <= temp_in; // [R16]
         if (first_q)
            temp_sec_q <= TEMP_SEC - 16'h0001;
         else if (sec_tick)
            temp_sec_q <= (temp_sec_q == 16'h0000) ? TEMP_SEC - 16'h0001
               : temp_sec_q - 16'h0001; // [R16]
      end
   end

   // measurement scheduler; a scheduled save waits for idle, a rezero save does not, and neither can stop
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         meas_sec_q <= 16'h0000;
         pend_q <= 1'b0;
         mon_busy <= 1'b0;
         offline_meas <= 1'b0;
         busy_cnt_q <= 32'h00000000;
      end
      else if (ce)
      begin
         if (first_q)
            meas_sec_q <= MEAS_SEC;
         else if (rezero & ~dex)
         begin
            meas_sec_q <= MEAS_SEC; // [R4]
            pend_q <= 1'b0;
         end
         else if (sec_tick & ~dex & (meas_sec_q != 16'h0000))
            meas_sec_q <= meas_sec_q - 16'h0001;
         else if ((meas_sec_q == 16'h0000) & ~dex & ~first_q)
         begin
            pend_q <= 1'b1;
            meas_sec_q <= MEAS_SEC;
         end
         if (mon_busy)
         begin
            // no abort path: only the budget count ends it
            if (busy_cnt_q == 32'h00000000)
            begin
               mon_busy <= 1'b0; // [R7]
               offline_meas <= 1'b0;
            end
            else
               busy_cnt_q <= busy_cnt_q - 32'h00000001;
         end
         else if (~dex & (rezero | (pend_q & host_idle))) // [R1] [R4] [R6]
         begin
            mon_busy <= 1'b1;
            offline_meas <= ~performance_priority_bit; // [R2]
            busy_cnt_q <= performance_priority_bit ? ON_DLY - 1 : FULL_DLY - 1; // [R8]
            if (~rezero)
               pend_q <= 1'b0;
         end
      end
   end

   // per-attribute window evaluation for the current operation
   always @*
   begin
      ic_n = sat16(ic_q[op_attr]); // [R11] [R23]
      fc_n = op_error ? sat16(fc_q[op_attr]) : fc_q[op_attr];
      hist_n = hist_q[op_attr];
      pf_set = 1'b0;
      pf_at = op_attr;
      if (ic_n >= INTERVAL)
      begin
         if (fc_n > ERR_THR) // [R12]
            hist_n = (hist_q[op_attr] == 8'hFF) ? 8'hFF : hist_q[op_attr] + 8'h01; // [R14]
         else if (hist_q[op_attr] != 8'h00)
            hist_n = hist_q[op_attr] - 8'h01; // [R14]
         pf_set = op_valid & ~dex & (hist_n >= PRED_THR); // [R15]
      end
   end

   // counters update only while monitoring is enabled
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         for (i = 0; i < NATTR; i = i + 1)
         begin
            ic_q[i] <= 16'h0000;
            fc_q[i] <= 16'h0000;
            hist_q[i] <= 8'h00;
         end
      end
      else if (ce & op_valid & ~dex) // [R1] [R3]
      begin
         hist_q[op_attr] <= hist_n;
         if (ic_n >= INTERVAL)
         begin
            ic_q[op_attr] <= 16'h0000; // [R13]
            fc_q[op_attr] <= 16'h0000; // [R13]
         end
         else
         begin
            ic_q[op_attr] <= ic_n;
            fc_q[op_attr] <= fc_n;
         end
      end
   end

   // sticky report flags; a set wins over a clear in the same cycle
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         pf_q <= 1'b0;
         tw_q <= 1'b0;
         rnd_q <= 1'b0;
         pf_attr_q <= {AW{1'b0}};
         nv_pf_write <= 1'b0;
         sense_code <= 32'h00000000;
      end
      else if (ce)
      begin
         nv_pf_write <= pf_set & ~pf_q; // [R10]
         if (first_q & nv_pf_in)
         begin
            pf_q <= 1'b1; // [R10]
            sense_code <= {`DHTM_KEY_REC, `DHTM_ASC_PF, 8'h00, temp_in};
         end
         else if (pf_set)
         begin
            pf_q <= 1'b1;
            pf_attr_q <= pf_at;
            sense_code <= {`DHTM_KEY_REC, `DHTM_ASC_PF, {(8-AW){1'b0}}, pf_at,
               temp_q}; // [R9] [R18]
         end
         else if (tw_set & ~pf_q) // a standing failure code keeps priority
            sense_code <= {`DHTM_KEY_REC, `DHTM_ASC_TW, `DHTM_ASCQ_TW,
               temp_in}; // [R17] [R18]
         else if (wr_reft & ref_over & ~pf_q)
            sense_code <= {`DHTM_KEY_REC, `DHTM_ASC_RND, `DHTM_ASCQ_RND,
               temp_q}; // [R22]
         // bus reset spares the failure flag so it is not lost
         if (~pf_set & ~(first_q & nv_pf_in) & wr_stat & s_axi_wdata[`DHTM_ST_PF])
            pf_q <= 1'b0;
         if (tw_set)
            tw_q <= 1'b1; // [R17]
         else if (bus_reset_in | (wr_stat & s_axi_wdata[`DHTM_ST_TW]))
            tw_q <= 1'b0;
         if (wr_reft & ref_over)
            rnd_q <= 1'b1; // [R22]
         else if (bus_reset_in | (wr_stat & s_axi_wdata[`DHTM_ST_RND]))
            rnd_q <= 1'b0;
      end
   end

endmodule // dhtm_top

// File: bench/dhtm_asserts.sv
// assertion checker for the drive health monitor top
`timescale 1ns/1ps
`include "dhtm_consts.vh"
module dhtm_asserts #(
   parameter FULL_DLY = 30
) (
   // clock, reset, enable
   input wire clk,
   input wire reset,
   input wire ce,
   // register bus
   input wire s_axi_awvalid,
   input wire s_axi_wvalid,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_arvalid,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // reports
   input wire sense_valid,
   input wire [31:0] sense_code,
   input wire mon_busy,
   input wire offline_meas,
   input wire nv_pf_write
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   int busy_n;
   // enabled cycles of the current save; a long save means too much host delay
   always @(posedge clk or posedge reset)
   begin
      if (reset || !mon_busy)
         busy_n <= 0;
      else if (ce)
         busy_n <= busy_n + 1;
   end
   property p_wr_ans;
      ce && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
   property p_wr_block;
      s_axi_bvalid |-> !s_axi_awready;
   endproperty
   a_wr_block: assert property (p_wr_block) else $error("write taken while busy");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_rd_ans;
      ce && s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_busy_min;
      $rose(mon_busy) |=> mon_busy [*8];
   endproperty
   a_busy_min: assert property (p_busy_min) else $error("save cut short");
   property p_busy_max;
      busy_n <= FULL_DLY;
   endproperty
   a_busy_max: assert property (p_busy_max) else $error("save too long");
   property p_offl_busy;
      offline_meas |-> mon_busy;
   endproperty
   a_offl_busy: assert property (p_offl_busy) else $error("offline flag outside save");
   property p_pf_pulse;
      nv_pf_write |=> !nv_pf_write;
   endproperty
   a_pf_pulse: assert property (p_pf_pulse) else $error("record write too long");
   property p_sense_key;
      sense_valid && $past(sense_valid) |-> sense_code[31:24] == `DHTM_KEY_REC;
   endproperty
   a_sense_key: assert property (p_sense_key) else $error("bad sense key");
   c_save: cover property ($rose(mon_busy));
   c_sense: cover property (sense_valid);
   c_pf: cover property (nv_pf_write);
endmodule // dhtm_asserts

bind dhtm_top dhtm_asserts #(.FULL_DLY(FULL_DLY)) u_dhtm_asserts (.clk(clk), .reset(reset),
   .ce(ce), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .sense_valid(sense_valid),
   .sense_code(sense_code), .mon_busy(mon_busy), .offline_meas(offline_meas),
   .nv_pf_write(nv_pf_write));

// File: bench/dhtm_host.sv
// host initiator model on the axi4-lite register port
`timescale 1ns/1ps
module dhtm_host (
   // clock
   input wire clk,
   // write channels
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire wready,
   input wire [1:0] bresp,
   input wire bvalid,
   output logic bready,
   // read channels
   output logic [7:0] araddr,
   output logic arvalid,
   input wire arready,
   input wire [31:0] rdata,
   input wire [1:0] rresp,
   input wire rvalid,
   output logic rready
);
   // idle bus; answer readies stand only while an answer is awaited
   initial
   begin
      {awaddr, araddr, wdata} = 48'h0;
      {awvalid, wvalid, arvalid} = 3'h0;
      {bready, rready} = 2'h0;
      wstrb = 4'hF;
   end
   // address and data offered together, held until both are taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      {awvalid, wvalid} <= 2'h3;
      bready <= 1'b1;
      do @(negedge clk); while (awready !== 1'b1 || wready !== 1'b1);
      @(posedge clk);
      {awvalid, wvalid} <= 2'h0;
      do @(negedge clk); while (bvalid !== 1'b1);
      // response taken at the edge where bvalid and bready meet
      @(posedge clk);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask
   // one read, held until taken
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arvalid <= 1'b0;
      do @(negedge clk); while (rvalid !== 1'b1);
      // data taken at the edge where rvalid and rready meet
      @(posedge clk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
endmodule // dhtm_host

// File: bench/dhtm_top_tb.sv
// self-checking bench for the drive health monitor
`timescale 1ns/1ps
`include "dhtm_consts.vh"
module dhtm_top_tb;
   localparam OND = 20;
   localparam FULLD = 30;
   logic clk, reset, ce, op_valid, op_error, host_idle, rezero, bus_reset_in, nv_pf_in;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic sense_valid, mon_busy, offline_meas, nv_pf_write, pf_seen;
   logic [7:0] awaddr, araddr, temp_in;
   logic [31:0] wdata, rdata, sense_code, rd_v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp, op_attr;
   int miscompares, checked, n, off;
   dhtm_top #(.INTERVAL(16'h0004), .ERR_THR(16'h0001), .PRED_THR(8'h02), .SEC_CYC(10),
      .MEAS_SEC(16'h0005), .TEMP_SEC(16'h0003), .ON_DLY(OND), .FULL_DLY(FULLD)) u_dhtm_top (
      .clk(clk), .reset(reset), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .op_valid(op_valid), .op_attr(op_attr), .op_error(op_error), .host_idle(host_idle),
      .rezero(rezero), .bus_reset_in(bus_reset_in), .temp_in(temp_in), .nv_pf_in(nv_pf_in),
      .nv_pf_write(nv_pf_write), .sense_valid(sense_valid), .sense_code(sense_code),
      .mon_busy(mon_busy), .offline_meas(offline_meas));
   dhtm_host u_dhtm_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));
   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // remember any write of the failure record
   always @(posedge clk)
      if (nv_pf_write === 1'b1)
         pf_seen <= 1'b1;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task w(input logic [7:0] a, input logic [31:0] d);
      u_dhtm_host.wr(a, d, 4'hF, resp);
   endtask
   task r(input logic [7:0] a);
      u_dhtm_host.rd(a, rd_v, resp);
   endtask
   task pulse_rezero;
      rezero <= 1'b1;
      @(posedge clk);
      rezero <= 1'b0;
   endtask
   // one window of four operations, the first nerr of them failing
   task win(input logic [1:0] a, input int nerr);
      for (int i = 0; i < 4; i++)
      begin
         op_valid <= 1'b1;
         op_attr <= a;
         op_error <= (i < nerr);
         @(posedge clk);
      end
      op_valid <= 1'b0;
      @(posedge clk);
   endtask
   task t_regs;
      chk(sense_valid, 1'b0);
      r(`DHTM_OFF_CTRL);
      chk(rd_v, 32'h4);
      // byte lane 0 off: the control byte must not change
      u_dhtm_host.wr(`DHTM_OFF_CTRL, 32'h1, 4'h0, resp);
      r(`DHTM_OFF_CTRL);
      chk(rd_v, 32'h4);
      r(`DHTM_OFF_REFT);
      chk(rd_v, 32'h41);
      r(8'h18);
      chk(resp, 2'h2);
      w(`DHTM_OFF_SENSE, 32'h0);
      chk(resp, 2'h2);
   endtask
   task t_ref;
      w(`DHTM_OFF_REFT, 32'h50);
      r(`DHTM_OFF_REFT);
      chk(rd_v, 32'h41);
      w(`DHTM_OFF_CTRL, 32'h14);
      r(`DHTM_OFF_STAT);
      chk(rd_v & 32'h4, 32'h4);
      chk(sense_code >> 8, 32'h13700);
      w(`DHTM_OFF_STAT, 32'h4);
      w(`DHTM_OFF_REFT, 32'h28);
      r(`DHTM_OFF_REFT);
      chk(rd_v, 32'h28);
   endtask
   // over the user trip point only: gated first, then reported
   task t_temp;
      w(`DHTM_OFF_CTRL, 32'h10);
      temp_in <= 8'h30;
      cyc(35);
      r(`DHTM_OFF_STAT);
      chk(rd_v & 32'h2, 32'h0);
      r(`DHTM_OFF_TEMP);
      chk(rd_v, 32'h30);
      w(`DHTM_OFF_CTRL, 32'h14);
      cyc(35);
      r(`DHTM_OFF_STAT);
      chk(rd_v & 32'h2, 32'h2);
      chk(sense_code, 32'h010B0130);
   endtask
   task t_pf;
      w(`DHTM_OFF_CTRL, 32'h15);
      win(2'h1, 4);
      win(2'h1, 4);
      r(`DHTM_OFF_STAT);
      chk(rd_v & 32'h1, 32'h0);
      w(`DHTM_OFF_CTRL, 32'h14);
      win(2'h1, 1);
      win(2'h1, 4);
      win(2'h1, 0);
      win(2'h1, 4);
      r(`DHTM_OFF_STAT);
      chk(rd_v & 32'h1, 32'h0);
      win(2'h1, 4);
      r(`DHTM_OFF_STAT);
      chk(rd_v & 32'h1, 32'h1);
      chk((rd_v >> 8) & 32'h3, 32'h1);
      chk(sense_code >> 8, 32'h15D01);
      chk(pf_seen, 1'b1);
      bus_reset_in <= 1'b1;
      @(posedge clk);
      bus_reset_in <= 1'b0;
      r(`DHTM_OFF_STAT);
      chk(rd_v & 32'h1, 32'h1);
      chk(sense_valid, 1'b1);
      w(`DHTM_OFF_CTRL, 32'h4);
      chk(sense_valid, 1'b0);
   endtask
   task t_save;
      // a frozen block ignores a rezero
      ce <= 1'b0;
      pulse_rezero;
      cyc(3);
      chk(mon_busy, 1'b0);
      ce <= 1'b1;
      w(`DHTM_OFF_CTRL, 32'h16);
      pulse_rezero;
      n = 0;
      off = 0;
      repeat (60)
      begin
         @(negedge clk);
         n += (mon_busy === 1'b1);
         off += (offline_meas === 1'b1);
      end
      chk(n, OND);
      chk(off, 0);
      @(posedge clk);
      w(`DHTM_OFF_CTRL, 32'h14);
      pulse_rezero;
      r(`DHTM_OFF_TLEFT);
      chk(rd_v, 32'h5);
      chk(offline_meas, 1'b1);
      cyc(40);
   endtask
   task t_sched;
      cyc(70);
      r(`DHTM_OFF_STAT);
      chk(rd_v & 32'h28, 32'h20);
      host_idle <= 1'b1;
      n = 0;
      do @(posedge clk); while (mon_busy !== 1'b1 && ++n < 10);
      chk(mon_busy, 1'b1);
      host_idle <= 1'b0;
      cyc(40);
   endtask
   // main sequence
   initial
   begin
      {reset, ce, op_valid, op_error, host_idle, rezero, bus_reset_in, nv_pf_in} = 8'hC0;
      {op_attr, temp_in, pf_seen} = 11'h32;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      cyc(2);
      t_regs;
      t_ref;
      t_temp;
      t_pf;
      t_save;
      t_sched;
      nv_pf_in <= 1'b1;
      reset <= 1'b1;
      cyc(12);
      reset <= 1'b0;
      cyc(3);
      r(`DHTM_OFF_STAT);
      chk(rd_v & 32'h1, 32'h1);
      end_sim;
   end
   // watchdog against a hung handshake
   initial
   begin
      repeat (5000) @(posedge clk);
      miscompares++;
      end_sim;
   end
endmodule // dhtm_top_tb
